// ### cfg_pin_pkg.sv
// shared constants and types for the configuration control pin front-end
package cfg_pin_pkg;

  // clock and power-on-reset timing
  localparam int unsigned CLK_FREQ_KHZ = 40000;
  localparam int unsigned POR_SHORT_MS = 12;
  localparam int unsigned POR_LONG_MS = 100;
  localparam int unsigned POR_SHORT_CYCLES = POR_SHORT_MS * CLK_FREQ_KHZ;
  localparam int unsigned POR_LONG_CYCLES = POR_LONG_MS * CLK_FREQ_KHZ;
  localparam int unsigned POR_CNT_W = 23;
  localparam logic [1:0] SETTLE_LAST = 2'h3;

  // apb register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STRAP = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RECONF = 8'h0C;

  // control fields and reset values
  localparam int unsigned CTRL_JTAG_BIT = 0;
  localparam logic CTRL_JTAG_RESET = 1'b0;

  // status fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_REQ_BIT = 3;
  localparam int unsigned STAT_PIN_BIT = 4;
  localparam int unsigned STAT_EXP_BIT = 5;
  localparam int unsigned STAT_VALID_BIT = 6;

  // strap fields
  localparam int unsigned STRAP_POR_BIT = 0;
  localparam int unsigned STRAP_PULL_BIT = 1;
  localparam int unsigned STRAP_SCHEME_LSB = 2;

  localparam int unsigned RECONF_W = 8;

  typedef struct packed {
    logic por_short;
    logic pullup_off;
    logic [2:0] scheme;
  } strap_type;

  localparam strap_type STRAP_RESET = '{por_short: 1'b0, pullup_off: 1'b0, scheme: 3'h0};

  typedef struct packed {
    strap_type strap;
    logic request_n;
    logic status_n;
  } pin_sample_type;

  localparam int unsigned PIN_W = $bits(pin_sample_type);

  typedef enum logic [2:0] {
    ST_STRAP = 3'h0,
    ST_POR = 3'h1,
    ST_HOLD = 3'h3,
    ST_CONFIG = 3'h2,
    ST_USER = 3'h6,
    ST_RESET = 3'h7
  } cfg_state_type;

endpackage : cfg_pin_pkg

// ### pin_sync2.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_out = sync_q;

endmodule : pin_sync2

// ### por_timer.sv
// down-counter that times the power-on-reset delay
`timescale 1ns/1ps
module por_timer
  import cfg_pin_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [POR_CNT_W-1:0] load,
  output logic expired
);

  logic [POR_CNT_W-1:0] count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= load;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign expired = (count_q == '0);

endmodule : por_timer

// ### cfg_pin_frontend.sv
// configuration control pin front-end with apb status and control
//
// How it works
// - the power-on-reset delay is 12 ms when the delay strap is high and 100 ms when low.
// - pull-up strap high turns weak pull-ups off before and during configuration, low on.
// - the configuration scheme comes from the three-bit scheme select strap.
// - request low in user mode discards configuration, resets and tristates all I/O.
// - request returning high after being low starts a new configuration cycle.
// - configuration runs only while the request is high and is held off while low.
// - in jtag mode the request is ignored and neither blocks nor triggers configuration.
// - the open-drain status pin is driven low from power-up until the delay expires.
`timescale 1ns/1ps
module cfg_pin_frontend
  import cfg_pin_pkg::*;
#(
  parameter int unsigned POR_SHORT_CYCLES_P = POR_SHORT_CYCLES,
  parameter int unsigned POR_LONG_CYCLES_P = POR_LONG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_delay_sel,
  input wire logic pullup_off_sel,
  input wire logic [2:0] scheme_select,
  input wire logic config_request_n,
  input wire logic config_status_n_i,
  output logic config_status_n_o,
  output logic config_status_n_oe,
  input wire logic engine_done,
  output logic config_start,
  output logic config_clear,
  output logic config_active,
  output logic user_mode,
  output logic io_tristate,
  output logic weak_pullup_en,
  output logic [2:0] cfg_scheme
);

  // pin synchronisation
  pin_sample_type pins_raw;
  pin_sample_type pins;
  logic [PIN_W-1:0] pins_sync;

  assign pins_raw = '{
    strap: '{por_short: por_delay_sel, pullup_off: pullup_off_sel, scheme: scheme_select},
    request_n: config_request_n,
    status_n: config_status_n_i
  };

  pin_sync2 #(
    .WIDTH(PIN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign pins = pin_sample_type'(pins_sync);

  // state and control registers
  cfg_state_type state_q;
  cfg_state_type state_d;
  strap_type strap_q;
  logic strap_valid_q;
  logic [1:0] settle_q;
  logic jtag_q;
  logic [RECONF_W-1:0] reconf_q;
  logic por_expired;
  logic por_start;
  logic [POR_CNT_W-1:0] por_load;
  logic req_low;
  logic req_ok;

  assign req_low = !pins.request_n;
  assign req_ok = pins.request_n || jtag_q;
  assign por_start = (state_q == ST_STRAP) && (settle_q == SETTLE_LAST);
  assign por_load = pins.strap.por_short ? POR_CNT_W'(POR_SHORT_CYCLES_P - 1)
                                         : POR_CNT_W'(POR_LONG_CYCLES_P - 1);

  por_timer u_por (
    .pclk(pclk),
    .presetn(presetn),
    .start(por_start),
    .load(por_load),
    .expired(por_expired)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STRAP: begin
        if (por_start) begin
          state_d = ST_POR;
        end
      end
      ST_POR: begin
        if (por_expired) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (req_ok) begin
          state_d = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (!req_ok) begin
          state_d = ST_RESET;
        end else if (engine_done) begin
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        if (!req_ok) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        if (req_ok) begin
          state_d = ST_HOLD;
        end
      end
      default: begin
        state_d = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STRAP;
      settle_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (settle_q != SETTLE_LAST) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // straps are sampled once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= STRAP_RESET;
      strap_valid_q <= 1'b0;
    end else if (por_start) begin
      strap_q <= pins.strap;
      strap_valid_q <= 1'b1;
    end
  end

  // outputs follow the next state so they line up with state_q
  logic status_oe_q;
  logic start_q;
  logic clear_q;
  logic active_q;
  logic user_q;
  logic tristate_q;
  logic pullup_q;
  logic [2:0] scheme_q;
  logic pull_next;

  assign pull_next = (state_q == ST_STRAP) ? !pins.strap.pullup_off : !strap_q.pullup_off;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_oe_q <= 1'b1;
      start_q <= 1'b0;
      clear_q <= 1'b0;
      active_q <= 1'b0;
      user_q <= 1'b0;
      tristate_q <= 1'b1;
      pullup_q <= 1'b0;
      scheme_q <= 3'h0;
    end else begin
      status_oe_q <= (state_d == ST_STRAP) || (state_d == ST_POR);
      start_q <= (state_d == ST_CONFIG) && (state_q != ST_CONFIG);
      clear_q <= (state_d == ST_RESET) && (state_q != ST_RESET);
      active_q <= (state_d == ST_CONFIG);
      user_q <= (state_d == ST_USER);
      tristate_q <= (state_d != ST_USER);
      pullup_q <= (state_d != ST_USER) && pull_next;
      scheme_q <= (state_d == ST_STRAP) ? 3'h0 : (por_start ? pins.strap.scheme : strap_q.scheme);
    end
  end

  assign config_status_n_o = 1'b0;
  assign config_status_n_oe = status_oe_q;
  assign config_start = start_q;
  assign config_clear = clear_q;
  assign config_active = active_q;
  assign user_mode = user_q;
  assign io_tristate = tristate_q;
  assign weak_pullup_en = pullup_q;
  assign cfg_scheme = scheme_q;

  // apb slave
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic addr_hit;
  logic apb_write;
  logic [31:0] rdata;
  logic [31:0] status_word;
  logic [31:0] strap_word;

  assign addr_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                    (paddr == REG_STRAP) || (paddr == REG_RECONF);
  assign apb_write = psel && penable && pwrite && pready_q;

  assign status_word = {25'h0, strap_valid_q, por_expired, pins.status_n, pins.request_n,
                        state_q};
  assign strap_word = {27'h0, strap_q.scheme, strap_q.pullup_off, strap_q.por_short};
  assign rdata = (paddr == REG_CTRL) ? {31'h0, jtag_q} :
                 (paddr == REG_STATUS) ? status_word :
                 (paddr == REG_STRAP) ? strap_word :
                 (paddr == REG_RECONF) ? {24'h0, reconf_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !addr_hit;
      prdata_q <= (psel && !penable && !pwrite) ? rdata : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jtag_q <= CTRL_JTAG_RESET;
    end else if (apb_write && (paddr == REG_CTRL)) begin
      jtag_q <= pwdata[CTRL_JTAG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reconf_q <= '0;
    end else if (clear_q) begin
      reconf_q <= reconf_q + 1'b1;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // checks
  logic [POR_CNT_W-1:0] por_age_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_age_q <= '0;
    end else if (state_q == ST_POR) begin
      por_age_q <= por_age_q + 1'b1;
    end
  end

  property p_por_length;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_POR && state_d != ST_POR) |->
        por_age_q == (strap_q.por_short ? POR_CNT_W'(POR_SHORT_CYCLES_P - 1)
                                        : POR_CNT_W'(POR_LONG_CYCLES_P - 1));
  endproperty
  a_por_length: assert property (p_por_length) else $error("por delay length wrong");

  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
      (state_q != ST_STRAP && state_q != ST_USER) |-> (weak_pullup_en == !strap_q.pullup_off);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up state wrong");

  property p_scheme;
    @(posedge pclk) disable iff (!presetn)
      config_start |-> (cfg_scheme == strap_q.scheme) && strap_valid_q;
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme not from strap");

  property p_user_reset;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_USER && !jtag_q && req_low) |=>
        config_clear && io_tristate && !user_mode ##1 !config_clear;
  endproperty
  a_user_reset: assert property (p_user_reset) else $error("no reset on request");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_RESET && !req_low && !jtag_q) |-> ##[1:2] config_start;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on release");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_HOLD && req_low && !jtag_q) |=> !config_active && !config_start;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("config while held off");

  property p_jtag_ignore;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_USER && jtag_q) |=> user_mode && !config_clear;
  endproperty
  a_jtag_ignore: assert property (p_jtag_ignore) else $error("request seen in jtag mode");

  property p_status_low;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_STRAP || state_q == ST_POR) |-> config_status_n_oe && !config_status_n_o;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status not driven low");

  property p_status_release;
    @(posedge pclk) disable iff (!presetn)
      $fell(config_status_n_oe) |-> $past(state_q) == ST_POR && $past(por_expired);
  endproperty
  a_status_release: assert property (p_status_release) else $error("early release");

  property p_strap_hold;
    @(posedge pclk) disable iff (!presetn)
      (strap_valid_q && $past(strap_valid_q)) |-> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

endmodule : cfg_pin_frontend

// ### cfg_board_model.sv
// board-side host model: strap levels, request line, pulled-up status line
`timescale 1ns/1ps
module cfg_board_model
  import cfg_pin_pkg::*;
(
  input wire logic config_status_n_o,
  input wire logic config_status_n_oe,
  output logic config_status_n_i,
  output logic config_request_n,
  output strap_type strap
);
  // open-drain line with external pull-up
  assign config_status_n_i = config_status_n_oe ? config_status_n_o : 1'b1;

  // request held low through power-up until supplies settle
  initial begin
    config_request_n = 1'b0;
    strap = STRAP_RESET;
  end

  task set(input logic req, input strap_type s);
    config_request_n <= req;
    strap <= s;
  endtask : set

  task set_req(input logic req);
    config_request_n <= req;
  endtask : set_req
endmodule : cfg_board_model

// ### test_cfg_pin_frontend.sv
// self-checking bench for the configuration control pin front-end
`timescale 1ns/1ps
module test_cfg_pin_frontend;
  import cfg_pin_pkg::*;
  localparam int NS = 20;
  localparam int NL = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic engine_done = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, req_n, st_i, st_o, st_oe, cstart, cclear, cactive, umode, iotri, wpu;
  logic [2:0] scheme;
  strap_type strap;
  int err_total = 0, n_checks = 0, cycles = 0, n_start = 0, n_clear = 0;

  always #12.5 pclk = ~pclk;

  cfg_board_model board (.config_status_n_o(st_o), .config_status_n_oe(st_oe),
    .config_status_n_i(st_i), .config_request_n(req_n), .strap(strap));

  cfg_pin_frontend #(.POR_SHORT_CYCLES_P(NS), .POR_LONG_CYCLES_P(NL)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_delay_sel(strap.por_short), .pullup_off_sel(strap.pullup_off),
    .scheme_select(strap.scheme), .config_request_n(req_n), .config_status_n_i(st_i),
    .config_status_n_o(st_o), .config_status_n_oe(st_oe), .engine_done(engine_done),
    .config_start(cstart), .config_clear(cclear), .config_active(cactive),
    .user_mode(umode), .io_tristate(iotri), .weak_pullup_en(wpu), .cfg_scheme(scheme));

  // pulse counters and watchdog
  always @(posedge pclk) begin
    cycles++;
    if (cstart === 1'b1) n_start <= n_start + 1;
    if (cclear === 1'b1) n_clear <= n_clear + 1;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task done_pulse;
    @(posedge pclk);
    engine_done <= 1'b1;
    @(posedge pclk);
    engine_done <= 1'b0;
    cyc(3);
    chk("user_mode", 1, umode);
    chk("io_tristate", 0, iotri);
  endtask : done_pulse

  // power-up with given straps and delay length
  task t_power(input logic ps, input logic pu, input logic [2:0] sc, input int n);
    int cnt;
    cnt = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    board.set(1'b0, '{por_short: ps, pullup_off: pu, scheme: sc});
    cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    while (st_oe === 1'b1 && cnt < 200) begin
      @(posedge pclk);
      cnt++;
    end
    chk("por_len", n + 4, cnt);
    cyc(3);
    chk("active_held", 0, cactive);
    chk("pullup_pre", {31'h0, !pu}, wpu);
    chk("scheme", {29'h0, sc}, scheme);
    board.set(1'b1, '{por_short: !ps, pullup_off: !pu, scheme: ~sc});
    cyc(6);
    chk("started", 1, cactive);
    chk("pullup_cfg", {31'h0, !pu}, wpu);
    rd(REG_STRAP, {27'h0, sc, pu, ps}, "strap_reg");
    done_pulse();
    $display("power-up test done");
  endtask : t_power

  task t_bus;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, r);
    wr(REG_STRAP, 32'hFFFFFFFF);
    rd(REG_STRAP, {27'h0, 3'h5, 1'b1, 1'b1}, "strap_ro");
    $display("bus test done");
  endtask : t_bus

  task t_reconf;
    int s0;
    int c0;
    s0 = n_start;
    c0 = n_clear;
    board.set_req(1'b0);
    cyc(8);
    chk("clear_pulse", c0 + 1, n_clear);
    chk("tristate", 1, iotri);
    chk("user_off", 0, umode);
    chk("held_off", 0, cactive);
    rd(REG_STATUS, 32'h77, "status_reg");
    rd(REG_RECONF, 1, "reconf_count");
    board.set_req(1'b1);
    cyc(6);
    chk("restart", s0 + 1, n_start);
    done_pulse();
    $display("reconfiguration test done");
  endtask : t_reconf

  task t_jtag;
    int s0;
    int c0;
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 1, "ctrl_jtag");
    s0 = n_start;
    c0 = n_clear;
    board.set_req(1'b0);
    cyc(8);
    chk("jtag_user", 1, umode);
    board.set_req(1'b1);
    cyc(8);
    chk("jtag_clear", c0, n_clear);
    chk("jtag_start", s0, n_start);
    wr(REG_CTRL, 32'h0);
    $display("jtag test done");
  endtask : t_jtag

  initial begin
    t_power(1'b1, 1'b1, 3'h5, NS);
    t_bus();
    t_reconf();
    t_jtag();
    t_power(1'b0, 1'b0, 3'h2, NL);
    end_of_test();
  end
endmodule : test_cfg_pin_frontend
